//--- bench/pbsp_host_bus.sv
`timescale 1ns/1ps

module pbsp_host_bus (
  // clock
  input  wire logic        core_clk,
  // host drivers
  input  wire logic        host_drive,
  input  wire logic [35:0] host_word,
  // device drivers
  input  wire logic [31:0] data_lines_out,
  input  wire logic [31:0] data_lines_oe,
  input  wire logic [3:0]  parity_lane_lines_out,
  input  wire logic [3:0]  parity_lane_lines_oe,
  // resolved wire, lane g is {parity[g], data[8g+7:8g]}
  output logic      [35:0] wire_word
);
  logic [35:0] last_word = 36'h0;
  wire  [35:0] dev_oe    = {parity_lane_lines_oe, data_lines_oe};
  wire  [35:0] dev_out   = {parity_lane_lines_out, data_lines_out};

  // host wins the sample edge: the device only lets go at that edge, its hold overlaps our setup
  assign wire_word = host_drive ? host_word : ((dev_oe & dev_out) | (~dev_oe & ~last_word));

  // released lines toggle every cycle so a stale word never reads as valid
  always @(posedge core_clk) begin
    last_word <= wire_word;
  end
endmodule : pbsp_host_bus

//--- bench/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic        core_clk = 1'b0, resetn = 1'b0, advance_or_load = 1'b0, read_write = 1'b1;
  logic        clock_gate_low = 1'b0, chip_select_low_a = 1'b1, chip_select_low_b = 1'b1;
  logic        chip_select_high = 1'b0, burst_order_select = 1'b0, output_enable_n = 1'b0;
  logic        sleep_request = 1'b0, host_drive = 1'b0, accept_ready;
  logic [17:0] address_lines = 18'h0;
  logic [3:0]  byte_lane_write_n = 4'hf, parity_lane_lines_out, parity_lane_lines_oe;
  logic [35:0] host_word = 36'h0, bus_word;
  logic [31:0] data_lines_out, data_lines_oe;
  int          miscompares = 0, num_checks = 0;
  // row nibbles: command, low address, lane enables, host data, expected word three rows later
  // command 0 read, 1 write, 2/3 advance with read_write 1/0, 4/5/6 deselect by each select
  logic [19:0] rows [39] = '{
    20'h10000, 20'h29000, 20'h29010, 20'h29020, 20'h10e30, 20'h01040, 20'h39050, 20'h39000, 20'h39002,
    20'h39003, 20'h42004, 20'h3900f, 20'h02002, 20'h50000, 20'h60000, 20'h29003, 20'h29000, 20'h29000,
    20'h00000, 20'h13000, 20'h01000, 20'h4008f, 20'h03000, 20'h29002, 20'h29000, 20'h29008, 20'h6000f,
    20'h29002, 20'h29003, 20'h29000,
    20'h01000, 20'h29000, 20'h29000, 20'h29002, 20'h2900f, 20'h60008, 20'h29003, 20'h29002, 20'h29000};

  always #12.5 core_clk = ~core_clk;

  pbsp_host_bus pbsp_host_bus_inst (.core_clk(core_clk), .host_drive(host_drive), .host_word(host_word),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .parity_lane_lines_out(parity_lane_lines_out),
    .parity_lane_lines_oe(parity_lane_lines_oe), .wire_word(bus_word));

  pbsp_port pbsp_port_inst (.core_clk(core_clk), .resetn(resetn), .address_lines(address_lines),
    .advance_or_load(advance_or_load), .read_write(read_write), .clock_gate_low(clock_gate_low),
    .byte_lane_write_n(byte_lane_write_n), .chip_select_low_a(chip_select_low_a),
    .chip_select_low_b(chip_select_low_b), .chip_select_high(chip_select_high),
    .burst_order_select(burst_order_select), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .data_lines_in(bus_word[31:0]), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .parity_lane_lines_in(bus_word[35:32]), .parity_lane_lines_out(parity_lane_lines_out),
    .parity_lane_lines_oe(parity_lane_lines_oe), .accept_ready(accept_ready));

  // f stands for word 1 after a lane 0 only overwrite with word 5
  function automatic logic [35:0] word_of(input logic [3:0] k);
    word_of = (k == 4'hf) ? 36'h111111155 : {9{k}};
  endfunction : word_of

  task automatic drv(input logic [19:0] r);
    logic [3:0] c;
    c = r[19:16];
    advance_or_load   <= (c == 4'h2) || (c == 4'h3);
    read_write        <= !((c == 4'h1) || (c == 4'h3) || (c == 4'h4));
    chip_select_low_a <= (c == 4'h4);
    chip_select_low_b <= (c == 4'h5);
    chip_select_high  <= (c != 4'h6);
    // advance rows carry a foreign upper address that must be ignored
    address_lines     <= {((c == 4'h2) || (c == 4'h3)) ? 14'h1234 : 14'h25a3, r[15:12]};
    byte_lane_write_n <= r[11:8];
    host_drive        <= (r[7:4] != 4'h0);
    host_word         <= word_of(r[7:4]);
  endtask : drv

  task automatic chk(input logic [3:0] ex);
    #2;
    num_checks++;
    // the full buffer only moves on enabled edges, so a gated edge holds ready low
    if ((data_lines_oe !== {32{ex != 4'h0}}) || (parity_lane_lines_oe !== {4{ex != 4'h0}})
        || (accept_ready !== !(clock_gate_low || sleep_request))) begin
      miscompares++;
      $display("Error %0t: drive enable or ready wrong, expected drive %0d", $time, ex != 4'h0);
    end
    if (ex != 4'h0) begin
      num_checks++;
      if ({parity_lane_lines_out, data_lines_out} !== word_of(ex)) begin
        miscompares++;
        $display("Error %0t: read word %h, expected %h", $time, {parity_lane_lines_out, data_lines_out},
                 word_of(ex));
      end
    end
  endtask : chk

  task automatic do_reset(input logic order);
    @(posedge core_clk);
    resetn             <= 1'b0;
    burst_order_select <= order;
    drv(20'h60000);
    repeat (20) @(posedge core_clk);
    chk(4'h0);
    @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      @(posedge core_clk);
      drv(rows[i]);
      chk(rows[i][3:0]);
    end
  endtask : run_rows

  task automatic final_report;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if ((miscompares == 0) && (num_checks > 0)) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    do_reset(1'b0);
    run_rows(0, 29);
    // suspend by clock gate, then by sleep, in the middle of a read burst
    @(posedge core_clk);
    drv(20'h01000);
    repeat (2) begin
      @(posedge core_clk);
      drv(20'h29000);
      chk(4'h0);
    end
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk);
      clock_gate_low <= (k < 2);
      sleep_request  <= (k == 2) || (k == 3);
      chk(4'h2);
    end
    @(posedge core_clk);
    chk(4'h3);
    @(posedge core_clk);
    output_enable_n <= 1'b1;
    chk(4'h0);
    @(posedge core_clk);
    output_enable_n <= 1'b0;
    drv(20'h60000);
    chk(4'hf);
    // second reset mid-run, array kept, interleaved order from here
    do_reset(1'b1);
    run_rows(30, 38);
    final_report;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    miscompares++;
    $display("Error %0t: run did not finish in time", $time);
    final_report;
  end
endmodule : testbench

//--- rtl/pbsp_pkg.sv
package pbsp_pkg;

  // array geometry
  localparam int LANE_W     = 9;
  localparam int DATA_LANE  = 8;
  localparam int LANES      = 4;
  localparam int ADDR_W     = 18;
  localparam int BURST_W    = 2;

  // pipeline depth between command capture and data transfer, in cycles
  localparam int PIPE_DEPTH = 2;

  // burst order select levels
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // reset values and the burst step increment
  localparam logic [BURST_W-1:0] STEP_RST  = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE  = 2'h1;
  localparam logic               DRIVE_RST = 1'b0;

  // one captured access on its way to the data bus
  typedef struct packed {
    logic                 active;
    logic                 write;
    logic [ADDR_W-1:0]    addr;
    logic [LANES-1:0]     lane_write_n;
  } pbsp_entry_type;

  localparam pbsp_entry_type ENTRY_IDLE = '{active: 1'b0, write: 1'b0, addr: '0, lane_write_n: '1};

  // next low address bits of a burst for a given start and step
  function automatic logic [BURST_W-1:0] burst_bits(input logic [BURST_W-1:0] start,
                                                     input logic [BURST_W-1:0] step,
                                                     input logic               order);
    if (order == ORDER_INTERLEAVED) begin
      burst_bits = start ^ step;
    end else begin
      burst_bits = BURST_W'(start + step);
    end
  endfunction : burst_bits

endpackage : pbsp_pkg

//--- rtl/pbsp_port.sv
`timescale 1ns/1ps

// Notes on behaviour
// - data moves two clock cycles after its access was captured, read or write.
// - reads and writes follow each other on consecutive cycles with no idle cycle.
// - clock gate high ignores synchronous inputs and freezes every internal register.
// - a gated edge leaves the data outputs exactly as if it never happened; accept_ready drops low while the buffer is full.
// - deselected load starts nothing, but pending transfers still complete.
// - data bus floats two cycles after a deselect or a write start.
// - selected only with both low selects low and the high select high.
// - load while selected captures new address and control.
// - load while deselected ends any burst in progress.
// - advance steps the burst counter and ignores the address inputs.
// - one loaded address yields four beats from the burst counter.
// - burst order input high gives interleaved order, low gives linear.
// - read-write sampled at load picks the access type; data two cycles later.
// - each 9-bit lane has its own low-true write enable, applied two cycles later.
// - lane enables are ignored on reads: read-write sampled high at a load, or any beat of a read burst.
// - address, input data and output data are registered on the rising edge.
// - output enable high floats the data pins at once; low allows read drive.
// - sleep request gates the internal clock while keeping stored contents.
// - burst beats keep the direction sampled at the load.
// - interleaved beats use start bits xor step 0,1,2,3, wrapping.
// - linear beats add one modulo four from the start, wrapping.
// - data pins are floating from reset onward.
module pbsp_port #(
  parameter int ADDR_W = pbsp_pkg::ADDR_W,
  parameter int LANES  = pbsp_pkg::LANES
) (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 resetn,
  // command pins
  input  wire logic [ADDR_W-1:0]                    address_lines,
  input  wire logic                                 advance_or_load,
  input  wire logic                                 read_write,
  input  wire logic                                 clock_gate_low,
  input  wire logic [LANES-1:0]                     byte_lane_write_n,
  input  wire logic                                 chip_select_low_a,
  input  wire logic                                 chip_select_low_b,
  input  wire logic                                 chip_select_high,
  // static and asynchronous controls
  input  wire logic                                 burst_order_select,
  input  wire logic                                 output_enable_n,
  input  wire logic                                 sleep_request,
  // data pins, split into input, output and enable
  input  wire logic [LANES*pbsp_pkg::DATA_LANE-1:0] data_lines_in,
  output logic      [LANES*pbsp_pkg::DATA_LANE-1:0] data_lines_out,
  output logic      [LANES*pbsp_pkg::DATA_LANE-1:0] data_lines_oe,
  input  wire logic [LANES-1:0]                     parity_lane_lines_in,
  output logic      [LANES-1:0]                     parity_lane_lines_out,
  output logic      [LANES-1:0]                     parity_lane_lines_oe,
  // command buffer status
  output logic                                      accept_ready
);

  localparam int DL   = pbsp_pkg::DATA_LANE;
  localparam int LW   = pbsp_pkg::LANE_W;
  localparam int BW   = pbsp_pkg::BURST_W;
  localparam int WORD = LANES * LW;

  // storage
  logic [WORD-1:0] mem [2**ADDR_W];

  // burst state
  logic                  burst_active;
  logic                  burst_write;
  logic [ADDR_W-1:0]     burst_base;
  logic [BW-1:0]         burst_step;
  logic [BW-1:0]         burst_low;

  // two-entry command buffer
  pbsp_pkg::pbsp_entry_type buf_q [pbsp_pkg::PIPE_DEPTH];
  logic [1:0]               buf_count;

  // output data register
  logic [WORD-1:0]       read_word;
  logic                  data_drive;

  // decode
  wire                   cycle_en;
  wire                   selected;
  wire                   do_load;
  wire                   do_stop;
  wire                   do_advance;
  wire [BW-1:0]          next_step;
  wire [BW-1:0]          next_low;
  wire                   buf_in_valid;
  wire                   buf_out_valid;
  wire                   buf_out_ready;
  wire                   buf_push;
  wire                   buf_pop;
  wire [WORD-1:0]        write_word;
  pbsp_pkg::pbsp_entry_type next_entry;
  pbsp_pkg::pbsp_entry_type head;

  // sleep gates the clock the same way the clock gate does; no edge reaches any register
  assign cycle_en   = !clock_gate_low && !sleep_request;
  assign selected   = !chip_select_low_a && !chip_select_low_b && chip_select_high;
  assign do_load    = cycle_en && !advance_or_load && selected;
  assign do_stop    = cycle_en && !advance_or_load && !selected;
  assign do_advance = cycle_en && advance_or_load && burst_active;
  assign next_step  = BW'(burst_step + pbsp_pkg::STEP_ONE);
  assign next_low   = pbsp_pkg::burst_bits(burst_base[BW-1:0], next_step, burst_order_select);

  // entry pushed this cycle; lane enables only count on writes
  always_comb begin
    next_entry = pbsp_pkg::ENTRY_IDLE;
    if (do_load) begin
      next_entry.active       = 1'b1;
      next_entry.write        = !read_write;
      next_entry.addr         = address_lines;
      next_entry.lane_write_n = read_write ? '1 : byte_lane_write_n;
    end else if (do_advance) begin
      next_entry.active       = 1'b1;
      next_entry.write        = burst_write;
      next_entry.addr         = {burst_base[ADDR_W-1:BW], next_low};
      next_entry.lane_write_n = burst_write ? byte_lane_write_n : '1;
    end
  end

  // every enabled edge pushes one entry; once two are held, every enabled edge also pops one
  assign buf_in_valid  = cycle_en;
  assign buf_out_valid = (buf_count == 2'(pbsp_pkg::PIPE_DEPTH));
  assign buf_out_ready = cycle_en;
  assign buf_pop       = buf_out_valid && buf_out_ready;
  assign accept_ready  = (buf_count < 2'(pbsp_pkg::PIPE_DEPTH)) || buf_pop;
  assign buf_push      = buf_in_valid && accept_ready;
  assign head          = buf_q[0];

  // burst counter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_base   <= '0;
      burst_step   <= pbsp_pkg::STEP_RST;
      burst_low    <= pbsp_pkg::STEP_RST;
    end else if (do_load) begin
      burst_active <= 1'b1;
      burst_write  <= !read_write;
      burst_base   <= address_lines;
      burst_step   <= pbsp_pkg::STEP_RST;
      burst_low    <= address_lines[BW-1:0];
    end else if (do_stop) begin
      burst_active <= 1'b0;
    end else if (do_advance) begin
      burst_step   <= next_step;
      burst_low    <= next_low;
    end
  end

  // command buffer; shifts only on enabled edges so a gated edge changes nothing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buf_q[0]  <= pbsp_pkg::ENTRY_IDLE;
      buf_q[1]  <= pbsp_pkg::ENTRY_IDLE;
      buf_count <= 2'h0;
    end else if (buf_pop) begin
      buf_q[0]  <= buf_q[1];
      buf_q[1]  <= next_entry;
    end else if (buf_push) begin
      buf_q[buf_count[0]] <= next_entry;
      buf_count           <= 2'(buf_count + 2'h1);
    end
  end

  // write lanes gathered from the pins at the transfer edge
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign write_word[g*LW +: LW]         = {parity_lane_lines_in[g], data_lines_in[g*DL +: DL]};
      assign data_lines_out[g*DL +: DL]     = read_word[g*LW +: DL];
      assign parity_lane_lines_out[g]       = read_word[g*LW + DL];
      // output enable works without the clock
      assign data_lines_oe[g*DL +: DL]      = {DL{data_drive && !output_enable_n}};
      assign parity_lane_lines_oe[g]        = data_drive && !output_enable_n;
    end
  endgenerate

  // no reset on the array: contents survive reset and sleep alike
  // one process writes every lane, so the array keeps a single writer
  always_ff @(posedge core_clk) begin
    for (int lane = 0; lane < LANES; lane++) begin
      if (buf_pop && head.active && head.write && !head.lane_write_n[lane]) begin
        mem[head.addr][lane*LW +: LW] <= write_word[lane*LW +: LW];
      end
    end
  end

  // output register; a write or deselect at the head floats the bus
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_drive <= pbsp_pkg::DRIVE_RST;
      read_word  <= '0;
    end else if (buf_pop) begin
      data_drive <= head.active && !head.write;
      if (head.active && !head.write) begin
        read_word <= mem[head.addr];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_read_latency;
    (do_load && read_write) ##1 cycle_en ##1 cycle_en |=> data_drive;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data not driven two cycles after load");

  property p_write_float;
    (do_load && !read_write) ##1 cycle_en ##1 cycle_en |=> !data_drive;
  endproperty
  a_write_float: assert property (p_write_float) else $error("bus not floated two cycles after write");

  property p_deselect_float;
    do_stop ##1 cycle_en ##1 cycle_en |=> !data_drive;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("deselect did not float bus");

  property p_suspend_hold;
    !cycle_en |=> $stable(read_word) && $stable(data_drive) && $stable(burst_step) && $stable(buf_count);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("state changed on a gated edge");

  property p_oe_float;
    output_enable_n |-> (data_lines_oe == '0) && (parity_lane_lines_oe == '0);
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("pins driven while output enable high");

  property p_wrap_four;
    do_advance [*4] |=> burst_step == $past(burst_step, 4);
  endproperty
  a_wrap_four: assert property (p_wrap_four) else $error("burst counter did not wrap after four beats");

  property p_linear_step;
    do_advance && !burst_order_select |=> burst_low == BW'($past(burst_low) + 2'h1);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear burst did not step by one");

  property p_interleave_step;
    do_advance && burst_order_select |=> (burst_low ^ burst_base[BW-1:0]) == burst_step;
  endproperty
  a_interleave_step: assert property (p_interleave_step) else $error("interleaved burst bits wrong");

  property p_upper_hold;
    do_advance |=> $stable(burst_base) && (buf_q[1].addr[ADDR_W-1:BW] == burst_base[ADDR_W-1:BW]);
  endproperty
  a_upper_hold: assert property (p_upper_hold) else $error("burst changed upper address bits");

  property p_burst_direction;
    do_advance |=> buf_q[1].write == $past(burst_write);
  endproperty
  a_burst_direction: assert property (p_burst_direction) else $error("burst beat changed direction");

  property p_deselect_stop;
    do_stop |=> !burst_active;
  endproperty
  a_deselect_stop: assert property (p_deselect_stop) else $error("deselect did not end the burst");

  property p_idle_advance;
    cycle_en && advance_or_load && !burst_active && buf_pop |=> !buf_q[1].active;
  endproperty
  a_idle_advance: assert property (p_idle_advance) else $error("idle advance started an access");

  property p_load_capture;
    do_load |=> burst_active && (burst_base == $past(address_lines)) && (burst_step == pbsp_pkg::STEP_RST);
  endproperty
  a_load_capture: assert property (p_load_capture) else $error("load did not capture the address");

  property p_advance_low;
    do_advance |=> buf_q[1].addr[BW-1:0] == burst_low;
  endproperty
  a_advance_low: assert property (p_advance_low) else $error("advance entry missed the counter");

  property p_load_direction;
    do_load && buf_pop |=> buf_q[1].write == !$past(read_write);
  endproperty
  a_load_direction: assert property (p_load_direction) else $error("load took the wrong direction");

  property p_read_lanes;
    do_load && read_write && buf_pop |=> buf_q[1].lane_write_n == '1;
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("lane enables kept on a read");

  property p_no_idle;
    cycle_en |-> buf_push;
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("enabled edge did not take a command");

  property p_gated_outputs;
    !cycle_en |=> $stable(data_lines_out) && $stable(parity_lane_lines_out);
  endproperty
  a_gated_outputs: assert property (p_gated_outputs) else $error("outputs moved on a gated edge");

  // reset itself must float the pins, so this one is not switched off by reset
  property p_reset_float;
    disable iff (1'b0) !resetn |=> (data_lines_oe == '0) && (parity_lane_lines_oe == '0);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pins driven after a reset edge");

endmodule : pbsp_port
